// ---- losc_pkg.sv ----
package losc_pkg;
  localparam logic [6:0] ADDR_BLOCK_EN = 7'h01;
  localparam logic [6:0] ADDR_INT_DIV = 7'h02;
  localparam logic [6:0] ADDR_FRAC_DIV = 7'h03;
  localparam logic [6:0] ADDR_MODULUS_DIVIDER = 7'h04;
  localparam logic [6:0] ADDR_PIN_MASK = 7'h10;
  localparam logic [6:0] ADDR_REF_OUT = 7'h21;
  localparam logic [6:0] ADDR_OSC_LODIV = 7'h22;
  localparam logic [6:0] ADDR_BALUN = 7'h30;
  localparam logic [6:0] ADDR_LIN_TRIM = 7'h31;
  localparam logic [6:0] ADDR_QUAD_POL = 7'h32;
  localparam logic [6:0] ADDR_INT_SET = 7'h49;
  localparam logic [6:0] ADDR_STATUS = 7'h7f;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int FRAME_BITS = 24;
  // Reset values
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_REF_OUT = 16'h0000;
  localparam logic [15:0] RST_OSC_LODIV = 16'h0000;
  localparam logic [15:0] RST_QUAD_POL = 16'h0600;
  // Field positions
  localparam int UNIT_RATE_BIT = 7;
  localparam int DOUBLE_RATE_BIT = 8;
  localparam int TOS_LSB = 4;
  localparam int SENSE_BIT = 3;
  localparam int OSC_LSB = 0;
  localparam int QDIV_BIT = 3;
  localparam int EDIV_BIT = 4;
  localparam int HALVE_BIT = 5;
  localparam int AMP_LSB = 6;
  localparam int BIN_LSB = 0;
  localparam int BOUT_LSB = 4;
  localparam int CTRIM_LSB = 0;
  localparam int RTRIM_LSB = 6;
  localparam int IPOL_LSB = 8;
  localparam int QPOL_LSB = 10;
  localparam logic [2:0] OSC_EXTERNAL = 3'h4;
  localparam logic [2:0] TOS_LOCK = 3'h0;
  localparam logic [2:0] TOS_CAL_BUSY = 3'h1;
  localparam logic [2:0] TOS_PIN = 3'h2;
  localparam logic [2:0] TOS_LOW = 3'h3;
  localparam logic [2:0] TOS_HIGH = 3'h4;
  localparam logic [1:0] SENSE_NORMAL = 2'h1;
  localparam logic [1:0] SENSE_INVERT = 2'h2;
  localparam int GATED_BLOCKS = 11;
  // Calibration length in detector reference cycles
  localparam int CAL_CYCLES = 94208;
  localparam int SETTLE_CYCLES = 64;
  typedef enum logic [3:0] {
    LOSC_IDLE = 4'b0001,
    LOSC_CAL = 4'b0010,
    LOSC_SETTLE = 4'b0100,
    LOSC_LOCKED = 4'b1000
  } losc_state_t;
  typedef struct packed {
    logic [2:0] oscCoreSel;
    logic externalLo;
    logic [3:0] finalLoRatio;
    logic [1:0] outputAmplitudeSel;
    logic doubleRateOut;
    logic unitRateOut;
    logic [1:0] iSense;
    logic [1:0] qSense;
    logic iInverted;
    logic qInverted;
    logic outBelowWhenQLeads;
  } losc_lo_cfg_t;
  typedef struct packed {
    logic [3:0] balunInputCap;
    logic [3:0] balunOutputCap;
    logic [6:0] resistiveTrim;
    logic [5:0] capacitiveTrim;
  } losc_trim_t;
endpackage

// ---- losc_serial_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module losc_serial_port
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic csN,
  input wire logic sclk,
  input wire logic sdioIn,
  output logic sdioOut,
  output logic sdioOe,
  output logic [6:0] regAddr,
  input wire logic [15:0] rdData,
  output logic wrStrobe,
  output logic [15:0] wrData
);
  logic [4:0] cnt_r, cnt_nxt;
  logic [6:0] addr_r, addr_nxt;
  logic rd_r, rd_nxt;
  logic [15:0] sh_r, sh_nxt;
  logic [4:0] dcnt_r, dcnt_nxt;
  logic sclkD_r, csD_r;
  logic wr_r, wr_nxt;
  logic [15:0] wd_r, wd_nxt;
  logic oe_r, oe_nxt;
  logic so_r, so_nxt;
  logic rise, fall, csEnd;

  assign rise = sclk & ~sclkD_r & ~csN;
  assign fall = ~sclk & sclkD_r & ~csN;
  assign csEnd = csN & ~csD_r;

  always_comb
  begin
    cnt_nxt = cnt_r;
    addr_nxt = addr_r;
    rd_nxt = rd_r;
    sh_nxt = sh_r;
    dcnt_nxt = dcnt_r;
    wr_nxt = 1'b0;
    wd_nxt = wd_r;
    oe_nxt = oe_r;
    so_nxt = so_r;
    if (csN)
    begin
      cnt_nxt = 5'h00;
      dcnt_nxt = 5'h00;
      oe_nxt = 1'b0;
      // Partial or overlong writes keep the latched tail
      if (csEnd && !rd_r && dcnt_r != 5'h00)
      begin
        wr_nxt = 1'b1;
        wd_nxt = sh_r;
      end
    end
    else if (rise)
    begin
      if (cnt_r < 5'd7)
        addr_nxt = {addr_r[5:0], sdioIn};
      else if (cnt_r == 5'd7)
        rd_nxt = sdioIn;
      else if (!rd_r)
      begin
        sh_nxt = {sh_r[14:0], sdioIn};
        if (dcnt_r != 5'h1f)
          dcnt_nxt = dcnt_r + 5'h01;
      end
      if (cnt_r != 5'h1f)
        cnt_nxt = cnt_r + 5'h01;
    end
    else if (fall && rd_r && cnt_r >= 5'd8)
    begin
      if (cnt_r == 5'd8)
        sh_nxt = rdData;
      else
        sh_nxt = {sh_r[14:0], 1'b0};
      so_nxt = (cnt_r == 5'd8) ? rdData[15] : sh_r[14];
      oe_nxt = (cnt_r < 5'd24);
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_r <= 5'h00;
      addr_r <= 7'h00;
      rd_r <= 1'b0;
      sh_r <= 16'h0000;
      dcnt_r <= 5'h00;
      sclkD_r <= 1'b0;
      csD_r <= 1'b1;
      wr_r <= 1'b0;
      wd_r <= 16'h0000;
      oe_r <= 1'b0;
      so_r <= 1'b0;
    end
    else if (ce)
    begin
      cnt_r <= cnt_nxt;
      addr_r <= addr_nxt;
      rd_r <= rd_nxt;
      sh_r <= sh_nxt;
      dcnt_r <= dcnt_nxt;
      sclkD_r <= sclk;
      csD_r <= csN;
      wr_r <= wr_nxt;
      wd_r <= wd_nxt;
      oe_r <= oe_nxt;
      so_r <= so_nxt;
    end
  end

  assign regAddr = addr_r;
  assign wrStrobe = wr_r;
  assign wrData = wd_r;
  assign sdioOut = so_r;
  assign sdioOe = oe_r;
endmodule
`default_nettype wire

// ---- losc_config_control.sv ----
// Function
// - Divider writes start band calibration automatically
// - Calibration lasts 94,208 reference cycles
// - Output select routes lock detect by default
// - Oscillator select value four picks external LO
// - Channel sense codes decoded per channel
// - Sideband placement follows channel sense pair
// - Double-rate and halving bits pick output rate
// - Unit-rate output path enable bit
// - Two-bit output amplitude select
// - Resistive and capacitive linearity trim fields
// - Balun input and output capacitance fields
// - Fast pin gates enabled, masked blocks
// - Final Final_lo_ratio by 2, 4, 8
// - Divide bits select ratio 2, 4, 8
// - Unmasked or disabled blocks ignore pin
// - Seven address, rw, sixteen data, MSB first
`timescale 1ns/1ps
`default_nettype none
module losc_config_control
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic csN,
  input wire logic sclk,
  input wire logic sdioIn,
  output logic sdioOut,
  output logic sdioOe,
  input wire logic fastEnablePin,
  input wire logic loopPhaseOk,
  output logic multiplexedOutputPin,
  output logic [10:0] blockEnableOut,
  output losc_pkg::losc_lo_cfg_t loCfg,
  output losc_pkg::losc_trim_t trimCfg,
  output logic detectorSense,
  output logic [13:0] internalSettings,
  output logic [15:0] integerDivider,
  output logic [15:0] fractionDivider,
  output logic [15:0] modulusValue,
  output logic calBusy
);
  logic [6:0] regAddr;
  logic wrStrobe;
  logic [15:0] wrData;
  logic [15:0] rdData;

  logic [15:0] blockEnables_r, blockEnables_nxt;
  logic [15:0] intDiv_r, intDiv_nxt;
  logic [15:0] fracDiv_r, fracDiv_nxt;
  logic [15:0] modDiv_r, modDiv_nxt;
  logic [15:0] pinGatingMask_r, pinGatingMask_nxt;
  logic [15:0] refOut_r, refOut_nxt;
  logic [15:0] oscLo_r, oscLo_nxt;
  logic [15:0] balun_r, balun_nxt;
  logic [15:0] linTrim_r, linTrim_nxt;
  logic [15:0] quadPol_r, quadPol_nxt;
  logic [15:0] intSet_r, intSet_nxt;
  logic [2:0] divSeen_r, divSeen_nxt;

  losc_pkg::losc_state_t state_r, state_nxt;
  logic [16:0] calCnt_r, calCnt_nxt;
  logic lock_r, lock_nxt;
  logic busy_r, busy_nxt;
  logic mux_r, mux_nxt;
  logic [10:0] blkEn_r, blkEn_nxt;
  losc_pkg::losc_lo_cfg_t loCfg_r, loCfg_nxt;
  logic [3:0] ratio;

  losc_serial_port u_port
  (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .csN(csN),
    .sclk(sclk),
    .sdioIn(sdioIn),
    .sdioOut(sdioOut),
    .sdioOe(sdioOe),
    .regAddr(regAddr),
    .rdData(rdData),
    .wrStrobe(wrStrobe),
    .wrData(wrData)
  );

  // Register writes
  always_comb
  begin
    blockEnables_nxt = blockEnables_r;
    intDiv_nxt = intDiv_r;
    fracDiv_nxt = fracDiv_r;
    modDiv_nxt = modDiv_r;
    pinGatingMask_nxt = pinGatingMask_r;
    refOut_nxt = refOut_r;
    oscLo_nxt = oscLo_r;
    balun_nxt = balun_r;
    linTrim_nxt = linTrim_r;
    quadPol_nxt = quadPol_r;
    intSet_nxt = intSet_r;
    divSeen_nxt = divSeen_r;
    // Clear first so a divider write in the same cycle still counts
    if (divSeen_r == 3'h7)
      divSeen_nxt = 3'h0;
    if (wrStrobe)
    begin
      case (regAddr)
        losc_pkg::ADDR_BLOCK_EN: blockEnables_nxt = wrData;
        losc_pkg::ADDR_INT_DIV:
        begin
          intDiv_nxt = wrData;
          divSeen_nxt[0] = 1'b1;
        end
        losc_pkg::ADDR_FRAC_DIV:
        begin
          fracDiv_nxt = wrData;
          divSeen_nxt[1] = 1'b1;
        end
        losc_pkg::ADDR_MODULUS_DIVIDER:
        begin
          modDiv_nxt = wrData;
          divSeen_nxt[2] = 1'b1;
        end
        losc_pkg::ADDR_PIN_MASK: pinGatingMask_nxt = wrData;
        losc_pkg::ADDR_REF_OUT: refOut_nxt = wrData;
        losc_pkg::ADDR_OSC_LODIV: oscLo_nxt = wrData;
        losc_pkg::ADDR_BALUN: balun_nxt = wrData;
        losc_pkg::ADDR_LIN_TRIM: linTrim_nxt = wrData;
        losc_pkg::ADDR_QUAD_POL: quadPol_nxt = wrData;
        losc_pkg::ADDR_INT_SET: intSet_nxt = wrData;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      blockEnables_r <= losc_pkg::RST_ZERO;
      intDiv_r <= losc_pkg::RST_ZERO;
      fracDiv_r <= losc_pkg::RST_ZERO;
      modDiv_r <= losc_pkg::RST_ZERO;
      pinGatingMask_r <= losc_pkg::RST_ZERO;
      refOut_r <= losc_pkg::RST_REF_OUT;
      oscLo_r <= losc_pkg::RST_OSC_LODIV;
      balun_r <= losc_pkg::RST_ZERO;
      linTrim_r <= losc_pkg::RST_ZERO;
      quadPol_r <= losc_pkg::RST_QUAD_POL;
      intSet_r <= losc_pkg::RST_ZERO;
      divSeen_r <= 3'h0;
    end
    else if (ce)
    begin
      blockEnables_r <= blockEnables_nxt;
      intDiv_r <= intDiv_nxt;
      fracDiv_r <= fracDiv_nxt;
      modDiv_r <= modDiv_nxt;
      pinGatingMask_r <= pinGatingMask_nxt;
      refOut_r <= refOut_nxt;
      oscLo_r <= oscLo_nxt;
      balun_r <= balun_nxt;
      linTrim_r <= linTrim_nxt;
      quadPol_r <= quadPol_nxt;
      intSet_r <= intSet_nxt;
      divSeen_r <= divSeen_nxt;
    end
  end

  // Readback; status word reports the calibration engine
  always_comb
  begin
    case (regAddr)
      losc_pkg::ADDR_BLOCK_EN: rdData = blockEnables_r;
      losc_pkg::ADDR_INT_DIV: rdData = intDiv_r;
      losc_pkg::ADDR_FRAC_DIV: rdData = fracDiv_r;
      losc_pkg::ADDR_MODULUS_DIVIDER: rdData = modDiv_r;
      losc_pkg::ADDR_PIN_MASK: rdData = pinGatingMask_r;
      losc_pkg::ADDR_REF_OUT: rdData = refOut_r;
      losc_pkg::ADDR_OSC_LODIV: rdData = oscLo_r;
      losc_pkg::ADDR_BALUN: rdData = balun_r;
      losc_pkg::ADDR_LIN_TRIM: rdData = linTrim_r;
      losc_pkg::ADDR_QUAD_POL: rdData = quadPol_r;
      losc_pkg::ADDR_INT_SET: rdData = intSet_r;
      losc_pkg::ADDR_STATUS: rdData = {12'h000, state_r};
      default: rdData = 16'h0000;
    endcase
  end

  // Calibration and lock sequencing
  always_comb
  begin
    state_nxt = state_r;
    calCnt_nxt = calCnt_r;
    // A new divider set restarts calibration from any state
    if (divSeen_r == 3'h7)
    begin
      state_nxt = losc_pkg::LOSC_CAL;
      calCnt_nxt = 17'(losc_pkg::CAL_CYCLES - 1);
    end
    else
    begin
      case (state_r)
        losc_pkg::LOSC_IDLE: ;
        losc_pkg::LOSC_CAL:
        begin
          if (calCnt_r == 17'h00000)
          begin
            state_nxt = losc_pkg::LOSC_SETTLE;
            calCnt_nxt = 17'(losc_pkg::SETTLE_CYCLES - 1);
          end
          else
            calCnt_nxt = calCnt_r - 17'h00001;
        end
        losc_pkg::LOSC_SETTLE:
        begin
          if (calCnt_r != 17'h00000)
            calCnt_nxt = calCnt_r - 17'h00001;
          else if (loopPhaseOk)
            state_nxt = losc_pkg::LOSC_LOCKED;
        end
        losc_pkg::LOSC_LOCKED:
        begin
          if (!loopPhaseOk)
            state_nxt = losc_pkg::LOSC_SETTLE;
        end
        default: state_nxt = losc_pkg::LOSC_IDLE;
      endcase
    end
    lock_nxt = (state_nxt == losc_pkg::LOSC_LOCKED);
    busy_nxt = (state_nxt == losc_pkg::LOSC_CAL);
  end

  // Output mux and LO configuration decode
  always_comb
  begin
    case (refOut_r[losc_pkg::TOS_LSB +: 3])
      losc_pkg::TOS_LOCK: mux_nxt = lock_nxt;
      losc_pkg::TOS_CAL_BUSY: mux_nxt = busy_nxt;
      losc_pkg::TOS_PIN: mux_nxt = fastEnablePin;
      losc_pkg::TOS_LOW: mux_nxt = 1'b0;
      losc_pkg::TOS_HIGH: mux_nxt = 1'b1;
      default: mux_nxt = 1'b0;
    endcase
    case (oscLo_r[losc_pkg::EDIV_BIT -: 2])
      2'b00: ratio = 4'd2;
      2'b01: ratio = 4'd4;
      2'b11: ratio = 4'd8;
      default: ratio = 4'd0;
    endcase
    loCfg_nxt.oscCoreSel = oscLo_r[losc_pkg::OSC_LSB +: 3];
    loCfg_nxt.externalLo = (oscLo_r[losc_pkg::OSC_LSB +: 3] == losc_pkg::OSC_EXTERNAL);
    loCfg_nxt.finalLoRatio = ratio;
    loCfg_nxt.outputAmplitudeSel = oscLo_r[losc_pkg::AMP_LSB +: 2];
    // Double rate needs the halving stage off; otherwise the LO rate
    loCfg_nxt.doubleRateOut = blockEnables_r[losc_pkg::DOUBLE_RATE_BIT] & ~oscLo_r[losc_pkg::HALVE_BIT];
    loCfg_nxt.unitRateOut = blockEnables_r[losc_pkg::UNIT_RATE_BIT];
    loCfg_nxt.iSense = quadPol_r[losc_pkg::IPOL_LSB +: 2];
    loCfg_nxt.qSense = quadPol_r[losc_pkg::QPOL_LSB +: 2];
    loCfg_nxt.iInverted = (quadPol_r[losc_pkg::IPOL_LSB +: 2] == losc_pkg::SENSE_INVERT);
    loCfg_nxt.qInverted = (quadPol_r[losc_pkg::QPOL_LSB +: 2] == losc_pkg::SENSE_NORMAL);
    // Only one inverted channel flips the sideband
    loCfg_nxt.outBelowWhenQLeads = ~(loCfg_nxt.iInverted ^ loCfg_nxt.qInverted);
  end

  // Per-block fast pin gating
  for (genvar b = 0; b < losc_pkg::GATED_BLOCKS; b++)
  begin : g_gate
    always_comb
    begin
      if (blockEnables_r[b] && pinGatingMask_r[b])
        blkEn_nxt[b] = fastEnablePin;
      else
        blkEn_nxt[b] = blockEnables_r[b];
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= losc_pkg::LOSC_IDLE;
      calCnt_r <= 17'h00000;
      lock_r <= 1'b0;
      busy_r <= 1'b0;
      mux_r <= 1'b0;
      blkEn_r <= 11'h000;
      loCfg_r <= '0;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
      calCnt_r <= calCnt_nxt;
      lock_r <= lock_nxt;
      busy_r <= busy_nxt;
      mux_r <= mux_nxt;
      blkEn_r <= blkEn_nxt;
      loCfg_r <= loCfg_nxt;
    end
  end

  assign multiplexedOutputPin = mux_r;
  assign blockEnableOut = blkEn_r;
  assign loCfg = loCfg_r;
  assign calBusy = busy_r;
  assign trimCfg = {balun_r[losc_pkg::BIN_LSB +: 4], balun_r[losc_pkg::BOUT_LSB +: 4],
                    linTrim_r[losc_pkg::RTRIM_LSB +: 7], linTrim_r[losc_pkg::CTRIM_LSB +: 6]};
  assign detectorSense = refOut_r[losc_pkg::SENSE_BIT];
  assign internalSettings = intSet_r[13:0];
  assign integerDivider = intDiv_r;
  assign fractionDivider = fracDiv_r;
  assign modulusValue = modDiv_r;
endmodule
`default_nettype wire

// ---- losc_cfg_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module losc_cfg_sva
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic csN,
  input wire logic fastEnablePin,
  input wire logic sdioOe,
  input wire logic calBusy,
  input wire logic [10:0] blockEnableOut,
  input wire losc_pkg::losc_lo_cfg_t loCfg,
  input wire losc_pkg::losc_trim_t trimCfg
);
  logic [16:0] calCnt_r;
  logic [16:0] calCnt_nxt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  always_comb
  begin
    calCnt_nxt = calCnt_r;
    if (!calBusy)
      calCnt_nxt = 17'h00000;
    else if (ce)
      calCnt_nxt = calCnt_r + 17'h00001;
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      calCnt_r <= 17'h00000;
    else
      calCnt_r <= calCnt_nxt;
  end
  a_cal_length: assert property ($fell(calBusy) |-> calCnt_r == 17'(losc_pkg::CAL_CYCLES))
    else $error("cal length");
  a_cal_after_frame: assert property ($rose(calBusy) |-> $past(csN) && $past(csN, 2))
    else $error("cal start");
  a_ext_lo_sel: assert property (loCfg.externalLo == (loCfg.oscCoreSel == losc_pkg::OSC_EXTERNAL))
    else $error("ext lo");
  a_i_sense_code: assert property (loCfg.iSense inside {2'h1, 2'h2} |-> loCfg.iInverted == loCfg.iSense[1])
    else $error("i sense");
  a_q_sense_code: assert property (loCfg.qSense inside {2'h1, 2'h2} |-> loCfg.qInverted == loCfg.qSense[0])
    else $error("q sense");
  a_sideband_place: assert property (loCfg.iSense == 2'h2 && loCfg.qSense == 2'h1 |-> loCfg.outBelowWhenQLeads)
    else $error("sideband");
  a_oe_release: assert property (csN [*3] |-> !sdioOe)
    else $error("sdio oe");
  a_trim_static: assert property ($changed(trimCfg) |-> csN && $past(csN))
    else $error("trim change");
  // Two past samples cover one to three register stages behind the pin
  a_enable_cause: assert property ($changed(blockEnableOut) |-> csN || $past(fastEnablePin) != $past(fastEnablePin, 4))
    else $error("enable change");
endmodule
bind losc_config_control losc_cfg_sva u_losc_cfg_sva
(
  .clk(clk), .arst_n(arst_n), .ce(ce), .csN(csN), .fastEnablePin(fastEnablePin), .sdioOe(sdioOe),
  .calBusy(calBusy), .blockEnableOut(blockEnableOut), .loCfg(loCfg), .trimCfg(trimCfg)
);
`default_nettype wire

// ---- losc_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module losc_host_model
(
  input wire logic clk,
  output logic csN,
  output logic sclk,
  output logic sdioIn,
  input wire logic sdioOut,
  input wire logic sdioOe
);
  logic hostDrv;
  logic hostBit;
  int phaseClk;
  // Released line shows the inverse of the last bit, not a stale copy
  assign sdioIn = sdioOe ? sdioOut : (hostDrv ? hostBit : ~hostBit);
  initial
  begin
    csN = 1'b1;
    sclk = 1'b0;
    hostDrv = 1'b0;
    hostBit = 1'b0;
    phaseClk = 3;
  end
  // Clock idles low between frames; phaseClk below 2 would race read data
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] d, output logic [15:0] q);
    logic [23:0] f;
    f = {a, rd, d};
    q = 16'h0000;
    @(posedge clk);
    csN <= 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      sclk <= 1'b0;
      hostDrv <= !(rd && i < 16);
      if (!(rd && i < 16))
        hostBit <= f[i];
      repeat (phaseClk) @(posedge clk);
      if (rd && i < 16)
        q[i] = sdioOut;
      sclk <= 1'b1;
      repeat (phaseClk) @(posedge clk);
    end
    sclk <= 1'b0;
    hostDrv <= 1'b0;
    repeat (phaseClk) @(posedge clk);
    csN <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) \
  begin \
    nCompared++; \
    if ((got) !== (exp)) \
    begin \
      badCount++; \
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp); \
    end \
  end
module testbench;
  logic clk, arst_n, ce, csN, sclk, sdioIn, sdioOut, sdioOe, fastEnablePin, loopPhaseOk, multiplexed_output_pin, calBusy;
  logic detectorSense;
  logic [10:0] blockEnableOut;
  logic [13:0] internalSettings;
  logic [15:0] intDiv, fracDiv, modDiv, rdat;
  losc_pkg::losc_lo_cfg_t loCfg;
  losc_pkg::losc_trim_t trimCfg;
  int badCount = 0;
  int nCompared = 0;
  losc_config_control u_losc_config_control
  (
    .clk(clk), .arst_n(arst_n), .ce(ce), .csN(csN), .sclk(sclk), .sdioIn(sdioIn), .sdioOut(sdioOut),
    .sdioOe(sdioOe), .fastEnablePin(fastEnablePin), .loopPhaseOk(loopPhaseOk), .multiplexedOutputPin(multiplexed_output_pin),
    .blockEnableOut(blockEnableOut), .loCfg(loCfg), .trimCfg(trimCfg), .detectorSense(detectorSense),
    .internalSettings(internalSettings), .integerDivider(intDiv), .fractionDivider(fracDiv),
    .modulusValue(modDiv), .calBusy(calBusy)
  );
  losc_host_model u_host
  (
    .clk(clk), .csN(csN), .sclk(sclk), .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe(sdioOe)
  );
  task automatic printVerdict();
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    u_host.xfer(1'b0, a, d, rdat);
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    u_host.xfer(1'b1, a, 16'h0000, rdat);
    `CHK(rdat, e, "readback")
  endtask
  task automatic test_reset();
    logic [6:0] adr [11];
    adr = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h10, 7'h21, 7'h22, 7'h30, 7'h31, 7'h32, 7'h49};
    for (int i = 0; i < 11; i++)
      rd(adr[i], adr[i] == 7'h32 ? losc_pkg::RST_QUAD_POL : losc_pkg::RST_ZERO);
    rd(7'h05, 16'h0000);
    rd(7'h7f, 16'h0001);
    `CHK(loCfg.outBelowWhenQLeads, 1'b1, "sideband")
    `CHK(multiplexed_output_pin, 1'b0, "lock before cal")
    $display("test reset done");
  endtask
  task automatic test_lo();
    logic [15:0] v [3];
    v = '{16'h0004, 16'h0069, 16'h009b};
    wr(7'h01, 16'h0180);
    `CHK(loCfg.unitRateOut, 1'b1, "unit rate")
    for (int i = 0; i < 3; i++)
    begin
      wr(7'h22, v[i]);
      `CHK(loCfg.oscCoreSel, v[i][2:0], "core")
      `CHK(loCfg.externalLo, v[i][2:0] == 3'h4, "ext lo")
      `CHK(loCfg.finalLoRatio, v[i][4] ? 4'h8 : (v[i][3] ? 4'h4 : 4'h2), "ratio")
      `CHK(loCfg.outputAmplitudeSel, v[i][7:6], "level")
      `CHK(loCfg.doubleRateOut, !v[i][5], "double rate")
    end
    rd(7'h22, v[2]);
    $display("test lo done");
  endtask
  task automatic test_pol();
    logic [15:0] v [2];
    v = '{16'h0900, 16'h0600};
    for (int i = 0; i < 2; i++)
    begin
      wr(7'h32, v[i]);
      `CHK(loCfg.iSense, v[i][9:8], "i sense")
      `CHK(loCfg.qSense, v[i][11:10], "q sense")
      `CHK(loCfg.iInverted, v[i][9:8] == 2'h2, "i inv")
      `CHK(loCfg.qInverted, v[i][11:10] == 2'h1, "q inv")
    end
    `CHK(loCfg.outBelowWhenQLeads, 1'b1, "sideband")
    $display("test pol done");
  endtask
  task automatic test_trim();
    u_host.phaseClk = 5;
    wr(7'h30, 16'h00a5);
    wr(7'h31, 16'h156a);
    wr(7'h21, 16'h0008);
    wr(7'h49, 16'h14b4);
    `CHK(trimCfg.balunInputCap, 4'h5, "balun in")
    `CHK(trimCfg.balunOutputCap, 4'ha, "balun out")
    `CHK(trimCfg.resistiveTrim, 7'h55, "r trim")
    `CHK(trimCfg.capacitiveTrim, 6'h2a, "c trim")
    `CHK(detectorSense, 1'b1, "sense")
    `CHK(internalSettings, 14'h14b4, "settings")
    rd(7'h31, 16'h156a);
    u_host.phaseClk = 3;
    $display("test trim done");
  endtask
  task automatic test_enable();
    wr(7'h01, 16'h0435);
    wr(7'h10, 16'h0611);
    fastEnablePin <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(blockEnableOut, 11'h435 & ~11'h611, "pin low")
    fastEnablePin <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(blockEnableOut, 11'h435, "pin high")
    // Clock enable low must hide a pin change
    ce <= 1'b0;
    fastEnablePin <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(blockEnableOut, 11'h435, "frozen")
    ce <= 1'b1;
    fastEnablePin <= 1'b1;
    repeat (4) @(posedge clk);
    $display("test enable done");
  endtask
  task automatic test_cal();
    int n;
    logic early;
    early = 1'b0;
    wr(7'h02, 16'h0050);
    wr(7'h03, 16'h0100);
    `CHK(calBusy, 1'b0, "cal too soon")
    wr(7'h04, 16'h0200);
    `CHK(calBusy, 1'b1, "cal start")
    `CHK({intDiv, fracDiv, modDiv}, 48'h005001000200, "dividers")
    for (n = 0; n < 100000 && calBusy === 1'b1; n++)
    begin
      @(posedge clk);
      early = early | (multiplexed_output_pin !== 1'b0);
    end
    `CHK(n > losc_pkg::CAL_CYCLES - 20 && n <= losc_pkg::CAL_CYCLES, 1'b1, "cal length")
    for (n = 0; n < 200 && multiplexed_output_pin !== 1'b1; n++)
      @(posedge clk);
    `CHK(early, 1'b0, "lock in cal")
    `CHK(n >= losc_pkg::SETTLE_CYCLES - 2 && n <= losc_pkg::SETTLE_CYCLES + 4, 1'b1, "settle")
    for (int s = 1; s < 5; s++)
    begin
      wr(7'h21, {9'h000, s[2:0], 4'h8});
      `CHK(multiplexed_output_pin, s == 2 || s == 4, "mux code")
    end
    wr(7'h21, 16'h0008);
    `CHK(multiplexed_output_pin, 1'b1, "lock default")
    rd(7'h7f, 16'h0008);
    loopPhaseOk <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(multiplexed_output_pin, 1'b0, "lock lost")
    $display("test cal done");
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    repeat (110000) @(posedge clk);
    badCount++;
    $display("mismatch at %0t: watchdog expired", $time);
    printVerdict();
  end
  initial
  begin
    arst_n = 1'b0;
    ce = 1'b1;
    fastEnablePin = 1'b1;
    loopPhaseOk = 1'b1;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    test_reset();
    test_lo();
    test_pol();
    test_trim();
    test_enable();
    test_cal();
    printVerdict();
  end
endmodule
`default_nettype wire
